// *** rtl/ipf_level_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module ipf_level_decode
    import ipf_pkg::*;
(
    // Field and request
    input  wire logic [1:0] code,
    input  wire logic       src_req,
    // Qualified request
    output var ipf_qreq_s   qreq
);
    always_comb begin
        qreq = '0;
        unique case (ipf_code_e'(code))
            IPF_CODE_OFF: qreq.req   = 1'b0;
            IPF_CODE_L0:  qreq.level = 2'd0;
            IPF_CODE_L1:  qreq.level = 2'd1;
            IPF_CODE_L2:  qreq.level = 2'd2;
        endcase
        if (code != IPF_CODE_OFF) begin
            qreq.req = src_req;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ipf_pkg.sv ***
package ipf_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // Register offsets (word index on the plain port)
    localparam logic [7:0] SER_TMR_PRIO_OFS = 8'h08;
    localparam logic [7:0] PWM_ADC_PRIO_OFS = 8'h09;

    // Reset values
    localparam logic [15:0] SER_TMR_PRIO_RST = 16'h0000;
    localparam logic [15:0] PWM_ADC_PRIO_RST = 16'h0000;

    // Writable bits of the serial and timer register; 11-10 reserved
    localparam logic [15:0] SER_TMR_WR_MASK = 16'hF3FF;
    localparam logic [15:0] PWM_ADC_WR_MASK = 16'hFFFF;

    // Field positions (low bit of each 2-bit field)
    localparam int unsigned SERIAL0_RX_FULL_POS  = 14;
    localparam int unsigned SERIAL0_RX_ERROR_POS = 12;
    localparam int unsigned SERIAL0_TX_IDLE_POS  = 8;
    localparam int unsigned SERIAL0_TX_EMPTY_POS = 6;
    localparam int unsigned TIMER_A_CH3_POS      = 4;
    localparam int unsigned TIMER_A_CH2_POS      = 2;
    localparam int unsigned TIMER_A_CH1_POS      = 0;
    localparam int unsigned PWM_A_FAULT_POS      = 14;
    localparam int unsigned PWM_B_FAULT_POS      = 12;
    localparam int unsigned PWM_A_RELOAD_POS     = 10;
    localparam int unsigned PWM_B_RELOAD_POS     = 8;
    localparam int unsigned CONV_A_ZERO_POS      = 6;
    localparam int unsigned CONV_B_ZERO_POS      = 4;
    localparam int unsigned CONV_A_COMPLETE_POS  = 2;
    localparam int unsigned CONV_B_COMPLETE_POS  = 0;

    // Source count: 7 serial/timer, 8 pwm/converter
    localparam int unsigned NUM_SRC = 15;

    // Field code and decoded level
    typedef enum logic [1:0] {
        IPF_CODE_OFF = 2'b00,
        IPF_CODE_L0  = 2'b01,
        IPF_CODE_L1  = 2'b10,
        IPF_CODE_L2  = 2'b11
    } ipf_code_e;

    typedef logic [1:0] ipf_level_t;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ipf_bus_req_s;

    // Qualified request toward the core
    typedef struct packed {
        logic       req;
        ipf_level_t level;
    } ipf_qreq_s;

endpackage

// *** rtl/ipf_regfile.sv ***
`timescale 1ns/10ps
`default_nettype none
module ipf_regfile
    import ipf_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Register bus
    input  wire ipf_bus_req_s bus,
    // Register contents
    output logic [15:0]       ser_tmr_q,
    output logic [15:0]       pwm_adc_q,
    output logic [15:0]       rdata_q
);
    typedef struct packed {
        logic [15:0] ser;
        logic [15:0] pwm;
        logic [15:0] rd;
    } ipf_rf_s;

    ipf_rf_s st_q;
    ipf_rf_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.rd = 16'h0000;
        if (bus.wr && bus.addr == SER_TMR_PRIO_OFS) begin
            st_d.ser = bus.wdata & SER_TMR_WR_MASK;
        end
        if (bus.wr && bus.addr == PWM_ADC_PRIO_OFS) begin
            st_d.pwm = bus.wdata & PWM_ADC_WR_MASK;
        end
        // Unmapped reads return zero
        if (bus.rd && bus.addr == SER_TMR_PRIO_OFS) begin
            st_d.rd = st_q.ser & SER_TMR_WR_MASK;
        end
        if (bus.rd && bus.addr == PWM_ADC_PRIO_OFS) begin
            st_d.rd = st_q.pwm;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= {SER_TMR_PRIO_RST, PWM_ADC_PRIO_RST, 16'h0000};
        end else begin
            st_q <= st_d;
        end
    end

    assign ser_tmr_q = st_q.ser;
    assign pwm_adc_q = st_q.pwm;
    assign rdata_q   = st_q.rd;
endmodule
`default_nettype wire

// *** rtl/ipf_top.sv ***
// What this block does
// - Code 00 off, then levels 0,1,2
// - Sources reach only levels 0 to 2
// - Reset clears all fields, sources disabled
// - Serial/timer bits 11-10 read zero
// - Serial 0 fields at 15-14,13-12,9-8,7-6
// - Timer A ch3,ch2,ch1 at 5-4,3-2,1-0
// - PWM faults at 15-14 and 13-12
// - PWM reloads at 11-10 and 9-8
// - Converter zero-cross at 7-6 and 5-4
// - Converter A complete at 3-2
// - Converter B complete at 1-0
`timescale 1ns/10ps
`default_nettype none
module ipf_top
    import ipf_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [DATA_W-1:0]        reg_rdata,
    // Raw peripheral requests, same clock domain
    input  wire logic [NUM_SRC-1:0]  src_req,
    // Qualified requests toward the core
    output logic [NUM_SRC-1:0]       irq_req,
    output logic [2*NUM_SRC-1:0]     irq_level
);
    ipf_bus_req_s bus;
    logic [15:0]  ser_tmr;
    logic [15:0]  pwm_adc;
    logic [15:0]  rdata;
    logic [2*NUM_SRC-1:0] codes;
    ipf_qreq_s    qreq [NUM_SRC];

    typedef struct packed {
        logic [NUM_SRC-1:0]   req;
        logic [2*NUM_SRC-1:0] lvl;
    } ipf_out_s;

    ipf_out_s st_q;
    ipf_out_s st_d;

    assign bus = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

    ipf_regfile u_regfile (
        .core_clk  (core_clk),
        .rst       (rst),
        .bus       (bus),
        .ser_tmr_q (ser_tmr),
        .pwm_adc_q (pwm_adc),
        .rdata_q   (rdata)
    );

    // Source order: index 0..6 serial/timer, 7..14 pwm/converter
    always_comb begin
        codes = '0;
        codes[1:0]   = ser_tmr[SERIAL0_RX_FULL_POS +: 2];
        codes[3:2]   = ser_tmr[SERIAL0_RX_ERROR_POS +: 2];
        codes[5:4]   = ser_tmr[SERIAL0_TX_IDLE_POS +: 2];
        codes[7:6]   = ser_tmr[SERIAL0_TX_EMPTY_POS +: 2];
        codes[9:8]   = ser_tmr[TIMER_A_CH3_POS +: 2];
        codes[11:10] = ser_tmr[TIMER_A_CH2_POS +: 2];
        codes[13:12] = ser_tmr[TIMER_A_CH1_POS +: 2];
        codes[15:14] = pwm_adc[PWM_A_FAULT_POS +: 2];
        codes[17:16] = pwm_adc[PWM_B_FAULT_POS +: 2];
        codes[19:18] = pwm_adc[PWM_A_RELOAD_POS +: 2];
        codes[21:20] = pwm_adc[PWM_B_RELOAD_POS +: 2];
        codes[23:22] = pwm_adc[CONV_A_ZERO_POS +: 2];
        codes[25:24] = pwm_adc[CONV_B_ZERO_POS +: 2];
        codes[27:26] = pwm_adc[CONV_A_COMPLETE_POS +: 2];
        codes[29:28] = pwm_adc[CONV_B_COMPLETE_POS +: 2];
    end

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        ipf_level_decode u_dec (
            .code    (codes[2*i +: 2]),
            .src_req (src_req[i]),
            .qreq    (qreq[i])
        );
    end

    // Registered outputs add one cycle of latency to each request
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < NUM_SRC; i++) begin
            st_d.req[i]       = qreq[i].req;
            st_d.lvl[2*i +: 2] = qreq[i].level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign irq_req   = st_q.req;
    assign irq_level = st_q.lvl;
    assign reg_rdata = rdata;
endmodule
`default_nettype wire

// *** verification/ipf_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ipf_props
    import ipf_pkg::*;
(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst,
    // Register port
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [DATA_W-1:0]    reg_rdata,
    // Requests
    input wire logic [NUM_SRC-1:0]   src_req,
    input wire logic [NUM_SRC-1:0]   irq_req,
    input wire logic [2*NUM_SRC-1:0] irq_level
);
    wire logic w8 = reg_wr && reg_addr == SER_TMR_PRIO_OFS;
    wire logic w9 = reg_wr && reg_addr == PWM_ADC_PRIO_OFS;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> irq_req == '0 && irq_level == '0 && reg_rdata == '0)
        else $error("outputs not cleared");
    no_level3_a: assert property (
        (irq_level & (irq_level >> 1) & 30'h1555_5555) == '0)
        else $error("level three seen");
    req_cause_a: assert property (
        (irq_req & ~$past(src_req)) == '0)
        else $error("request without source");
    rsv_zero_a: assert property (
        $past(reg_rd) && $past(reg_addr) == SER_TMR_PRIO_OFS
        |-> reg_rdata[11:10] == 2'b00)
        else $error("reserved bits set");
    ser_rd_a: assert property (
        w8 ##1 reg_rd && reg_addr == SER_TMR_PRIO_OFS
        |=> reg_rdata == ($past(reg_wdata, 2) & SER_TMR_WR_MASK))
        else $error("serial register readback");
    pwm_rd_a: assert property (
        w9 ##1 reg_rd && reg_addr == PWM_ADC_PRIO_OFS
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("pwm register readback");
    off_code_a: assert property (
        w8 && reg_wdata[15:14] == 2'b00 ##1 !w8 |=> !irq_req[0])
        else $error("disabled source forwarded");
    top_code_a: assert property (
        w8 && reg_wdata[15:14] == 2'b11 ##1 src_req[0] && !w8
        |=> irq_req[0] && irq_level[1:0] == 2'd2)
        else $error("code three not level two");
endmodule
`default_nettype wire

// *** verification/ipf_src_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ipf_src_model
    import ipf_pkg::*;
(
    // Clock, reset, wanted levels
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [NUM_SRC-1:0] want,
    // Raw levels to the block
    output var logic [NUM_SRC-1:0]  src_req
);
    // Flopped so levels move just after an edge
    always_ff @(posedge core_clk) begin
        src_req <= rst ? '0 : want;
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ipf_pkg::*;
;
    logic [7:0]  reg_addr = '0;
    logic [15:0] reg_wdata = '0, d8, d9, reg_rdata, exp_q[$];
    logic [14:0] want = '0, src_req, irq_req, e_rq;
    logic [29:0] irq_level, e_lv;
    logic [1:0]  f;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
    int          err_count = 0, checks = 0, seed = 32'hddc7_052e;
    int          p8[7] = '{14, 12, 8, 6, 4, 2, 0};
    ipf_src_model i_ipf_src_model (.core_clk, .rst, .want, .src_req);
    ipf_top i_ipf_top (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .src_req, .irq_req, .irq_level);
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(string nm, logic [29:0] s, logic [29:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e);
        exp_q.push_back(e);
        bus(0, 1, a, '0);
    endtask
    task automatic stop_test;
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Read data stands one cycle only, so match it at that edge
    always @(posedge core_clk) begin
        if (rd_d) begin
            chk("rdata", 30'(reg_rdata), 30'(exp_q.pop_front()));
        end
        rd_d <= reg_rd;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rd(SER_TMR_PRIO_OFS, SER_TMR_PRIO_RST);
        rd(PWM_ADC_PRIO_OFS, PWM_ADC_PRIO_RST);
        for (int k = 0; k < 10; k++) begin
            d8 = k == 0 ? 16'hffff : k == 1 ? 16'h0000 : 16'($random(seed));
            d9 = 16'($random(seed));
            want <= k < 2 ? '1 : 15'($random(seed));
            bus(1, 0, SER_TMR_PRIO_OFS, d8);
            rd(SER_TMR_PRIO_OFS, d8 & SER_TMR_WR_MASK);
            bus(1, 0, PWM_ADC_PRIO_OFS, d9);
            rd(PWM_ADC_PRIO_OFS, d9);
            bus(1, 0, 8'h0a, d9);
            rd(8'h0a, 16'h0000);
            bus(0, 0, '0, '0);
            repeat (2) @(posedge core_clk);
            for (int i = 0; i < NUM_SRC; i++) begin
                f = i < 7 ? 2'(d8 >> p8[i]) : 2'(d9 >> (28 - 2 * i));
                e_lv[2*i +: 2] = f != 2'd0 ? f - 2'd1 : 2'd0;
                e_rq[i] = want[i] && f != 2'd0;
            end
            chk("irq_req", 30'(irq_req), 30'(e_rq));
            chk("irq_level", irq_level, e_lv);
        end
        rst <= 1;
        repeat (2) @(posedge core_clk);
        rst <= 0;
        rd(SER_TMR_PRIO_OFS, 16'h0000);
        rd(PWM_ADC_PRIO_OFS, 16'h0000);
        chk("irq_req", 30'(irq_req), '0);
        bus(0, 0, '0, '0);
        // Let the read checker see the last read before the verdict
        repeat (2) @(posedge core_clk);
        chk("pending reads", 30'(exp_q.size()), '0);
        stop_test;
    end
endmodule
bind ipf_top ipf_props i_ipf_props (.core_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .src_req, .irq_req, .irq_level);
`default_nettype wire
